// ### rx_pkg.sv
package rx_pkg;
	// Register offsets on the plain register port
	localparam logic [1:0] ADDR_CTRL   = 2'h0;
	localparam logic [1:0] ADDR_STATUS = 2'h1;
	localparam logic [1:0] ADDR_DATA   = 2'h2;
	localparam logic [1:0] ADDR_BAUD   = 2'h3;
	// Control field positions
	localparam int CTRL_ENABLE = 0;
	localparam int CTRL_DOUBLE = 1;
	localparam int CTRL_PODD   = 2;
	localparam int CTRL_PEN    = 3;
	localparam int CTRL_SIZE_L = 4;
	localparam int CTRL_SIZE_H = 6;
	// Status field positions
	localparam int ST_RXC = 7;
	localparam int ST_FRAME_ERR = 4;
	localparam int ST_DOR = 3;
	localparam int ST_UPE = 2;
	// Reset values
	localparam logic [7:0]  CTRL_RESET = 8'h00;
	localparam logic [15:0] BAUD_RESET = 16'h0000;
	// Sampling
	localparam logic [3:0] SAMPLES_NORMAL = 4'hf;
	localparam logic [3:0] SAMPLES_DOUBLE = 4'h7;
	localparam logic [3:0] VOTE_FIRST_N   = 4'h8;
	localparam logic [3:0] VOTE_LAST_N    = 4'ha;
	localparam logic [3:0] VOTE_FIRST_D   = 4'h4;
	localparam logic [3:0] VOTE_LAST_D    = 4'h6;
	localparam int FIFO_DEPTH = 2;

	typedef struct packed {
		logic       frame_err;
		logic       upe;
		logic [8:0] data;
	} rx_frame_t;

	// Field order follows the control register bit positions, enable in bit 0
	typedef struct packed {
		logic [2:0]  size;
		logic        par_en;
		logic        par_odd;
		logic        dbl;
		logic        en;
	} rx_cfg_t;
endpackage

// ### rx_fifo.sv
`timescale 1ns/100ps
module rx_fifo
	import rx_pkg::*;
#(
	parameter int DEPTH = FIFO_DEPTH
)(
	// Clock and reset
	input  wire logic      clk_in,
	input  wire logic      resetn_in,
	// Control
	input  wire logic      flush_in,
	input  wire logic      push_in,
	input  rx_frame_t      push_data_in,
	input  wire logic      pop_in,
	// Status
	output rx_frame_t      head_out,
	output logic           full_out,
	output logic           empty_out
);
	localparam int CW = $clog2(DEPTH + 1);
	localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

	rx_frame_t       mem_q [DEPTH];
	rx_frame_t       mem_d [DEPTH];
	logic [PW-1:0]   rd_q, rd_d, wr_q, wr_d;
	logic [CW-1:0]   cnt_q, cnt_d;
	logic            do_push, do_pop;

	assign full_out  = (cnt_q == CW'(DEPTH));
	assign empty_out = (cnt_q == '0);
	assign head_out  = mem_q[rd_q];
	assign do_pop    = pop_in & ~empty_out;
	assign do_push   = push_in & (~full_out | do_pop);

	always_comb
	begin
		mem_d = mem_q;
		rd_d  = rd_q;
		wr_d  = wr_q;
		cnt_d = cnt_q;
		if (flush_in)
		begin
			rd_d  = '0;
			wr_d  = '0;
			cnt_d = '0;
		end
		else
		begin
			if (do_push)
			begin
				mem_d[wr_q] = push_data_in;
				wr_d = (wr_q == PW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
			end
			if (do_pop)
				rd_d = (rd_q == PW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
			cnt_d = cnt_q + CW'(do_push) - CW'(do_pop);
		end
	end

	always_ff @(posedge clk_in or negedge resetn_in)
	begin
		if (!resetn_in)
		begin
			for (int i = 0; i < DEPTH; i++)
				mem_q[i] <= '0;
			rd_q  <= '0;
			wr_q  <= '0;
			cnt_q <= '0;
		end
		else
		begin
			mem_q <= mem_d;
			rd_q  <= rd_d;
			wr_q  <= wr_d;
			cnt_q <= cnt_d;
		end
	end
endmodule // rx_fifo

// ### uart_async_receiver.sv
// Functional notes
// - Parity error reads zero without parity checking
// - Upper bit enables checker, lower selects odd
// - Parity result stored with frame in buffer
// - Parity flag follows next readable character
// - Disable stops receiver at once, drops frame
// - Disabled receiver releases receive pin
// - Disable flushes the receive buffer
// - Sample 16x normal, 8x double speed
// - Falling edge starts detection, sample one
// - Start vote samples 8-10 or 4-6
// - Majority high start is noise, rehunt
// - Resynchronise timing on every start bit
// - Sixteen or eight sample states per bit
// - Bit equals majority of three centre samples
// - Recover data, parity, first stop only
// - Zero first stop sets frame error
// - New start accepted after last stop vote
// - Receive complete high while buffer unread
// - Two-character buffer, overrun on fourth start
// - Frame and parity error flags per frame, write has no effect
`timescale 1ns/100ps
module uart_async_receiver
	import rx_pkg::*;
(
	// Clock and reset
	input  wire logic        CLK_SYS_IN,
	input  wire logic        RESETN_IN,
	// Serial line
	input  wire logic        RXD_IN,
	output logic             RXD_OVERRIDE_OUT,
	// Register port
	input  wire logic [1:0]  ADDR_IN,
	input  wire logic [15:0] WDATA_IN,
	input  wire logic        WR_IN,
	input  wire logic        RD_IN,
	output logic [15:0]      RDATA_OUT
);
	typedef enum logic [1:0] {
		ST_IDLE  = 2'b00,
		ST_START = 2'b01,
		ST_BITS  = 2'b11
	} rx_state_t;

	// Register port state
	rx_cfg_t      cfg_q, cfg_d;
	logic [15:0]  baud_q, baud_d;
	logic [15:0]  rdata_q, rdata_d;
	// Sample tick divider
	logic [15:0]  div_q, div_d;
	logic         tick;
	// Line synchroniser
	logic         rxd_s1_q, rxd_s2_q, rxd_prev_q;
	// Receive engine
	rx_state_t    state_q, state_d;
	logic [3:0]   samp_q, samp_d;
	logic [3:0]   bit_q, bit_d;
	logic [1:0]   vote_q, vote_d;
	logic [10:0]  shift_q, shift_d;
	logic         hold_q, hold_d;
	rx_frame_t    hold_f_q, hold_f_d;
	logic         dor_pend_q, dor_pend_d;
	logic         dor_q, dor_d;
	// Buffer
	rx_frame_t    head;
	logic         full, empty, push, pop;

	logic [3:0]   last_samp, vfirst, vlast;
	logic [3:0]   frame_bits;
	logic [3:0]   nbits;
	logic         in_vote, voted, par_calc;
	rx_frame_t    new_f;

	assign last_samp = cfg_q.dbl ? SAMPLES_DOUBLE : SAMPLES_NORMAL;
	assign vfirst    = cfg_q.dbl ? VOTE_FIRST_D : VOTE_FIRST_N;
	assign vlast     = cfg_q.dbl ? VOTE_LAST_D : VOTE_LAST_N;
	assign nbits     = 4'h5 + {1'b0, cfg_q.size};
	// Data bits, optional parity, first stop bit only
	assign frame_bits = nbits + {3'h0, cfg_q.par_en} + 4'h1;
	assign in_vote   = (samp_q >= vfirst) && (samp_q <= vlast);
	assign voted     = (vote_q >= 2'd2);
	assign RXD_OVERRIDE_OUT = cfg_q.en;

	// Divider gives one sample tick per baud_q+1 cycles
	always_comb
	begin
		div_d = div_q;
		tick  = 1'b0;
		if (div_q == baud_q)
		begin
			div_d = '0;
			tick  = 1'b1;
		end
		else
			div_d = div_q + 16'h1;
	end

	always_ff @(posedge CLK_SYS_IN or negedge RESETN_IN)
	begin
		if (!RESETN_IN)
		begin
			div_q      <= '0;
			rxd_s1_q   <= 1'b1;
			rxd_s2_q   <= 1'b1;
			rxd_prev_q <= 1'b1;
		end
		else
		begin
			div_q    <= div_d;
			rxd_s1_q <= RXD_IN;
			rxd_s2_q <= rxd_s1_q;
			if (tick)
				rxd_prev_q <= rxd_s2_q;
		end
	end

	// Parity over the received data bits
	always_comb
	begin
		par_calc = cfg_q.par_odd;
		for (int i = 0; i < 9; i++)
			if (i < int'(nbits))
				par_calc = par_calc ^ shift_q[i];
	end

	always_comb
	begin
		new_f      = '0;
		new_f.data = shift_q[8:0];
		for (int i = 0; i < 9; i++)
			if (i >= int'(nbits))
				new_f.data[i] = 1'b0;
		// Parity bit sits right after data
		new_f.upe  = cfg_q.par_en & (par_calc ^ shift_q[nbits]);
		new_f.frame_err = ~voted;
	end

	assign pop  = RD_IN && (ADDR_IN == ADDR_DATA);
	assign push = hold_q && (!full || pop);

	// Receive engine
	always_comb
	begin
		state_d    = state_q;
		samp_d     = samp_q;
		bit_d      = bit_q;
		vote_d     = vote_q;
		shift_d    = shift_q;
		hold_d     = hold_q & ~push;
		hold_f_d   = hold_f_q;
		dor_pend_d = dor_pend_q;
		dor_d      = dor_q;
		if (pop && dor_pend_q && !full)
			dor_d = 1'b1;
		if (push)
		begin
			dor_d      = dor_pend_q;
			dor_pend_d = 1'b0;
		end
		if (!cfg_q.en)
		begin
			state_d    = ST_IDLE;
			hold_d     = 1'b0;
			dor_pend_d = 1'b0;
			dor_d      = 1'b0;
		end
		else if (tick)
		begin
			unique case (state_q)
				ST_IDLE:
					if (rxd_prev_q && !rxd_s2_q)
					begin
						state_d = ST_START;
						samp_d  = 4'h1;
						vote_d  = '0;
					end
				ST_START:
				begin
					samp_d = samp_q + 4'h1;
					if (in_vote && rxd_s2_q)
						vote_d = vote_q + 2'd1;
					if (samp_q == vlast)
					begin
						if (voted || (in_vote && rxd_s2_q && vote_q == 2'd1))
							state_d = ST_IDLE;
						else
						begin
							state_d = ST_BITS;
							bit_d   = '0;
							vote_d  = '0;
							if (hold_q && full)
								dor_pend_d = 1'b1;
						end
					end
				end
				ST_BITS:
				begin
					samp_d = (samp_q == last_samp) ? 4'h0 : samp_q + 4'h1;
					if (in_vote && rxd_s2_q)
						vote_d = vote_q + 2'd1;
					// Bit index advances after its last vote, so the start tail is not counted
					if (samp_q == vlast)
					begin
						shift_d[bit_q] = (vote_d >= 2'd2);
						if (bit_q == frame_bits - 4'h1)
						begin
							state_d  = ST_IDLE;
							hold_d   = 1'b1;
							hold_f_d = new_f;
							hold_f_d.frame_err = (vote_d < 2'd2);
						end
						vote_d = '0;
						bit_d  = bit_q + 4'h1;
					end
				end
				default: state_d = ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge CLK_SYS_IN or negedge RESETN_IN)
	begin
		if (!RESETN_IN)
		begin
			state_q    <= ST_IDLE;
			samp_q     <= '0;
			bit_q      <= '0;
			vote_q     <= '0;
			shift_q    <= '0;
			hold_q     <= 1'b0;
			hold_f_q   <= '0;
			dor_pend_q <= 1'b0;
			dor_q      <= 1'b0;
		end
		else
		begin
			state_q    <= state_d;
			samp_q     <= samp_d;
			bit_q      <= bit_d;
			vote_q     <= vote_d;
			shift_q    <= shift_d;
			hold_q     <= hold_d;
			hold_f_q   <= hold_f_d;
			dor_pend_q <= dor_pend_d;
			dor_q      <= dor_d;
		end
	end

	rx_fifo #(
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.clk_in       (CLK_SYS_IN),
		.resetn_in    (RESETN_IN),
		.flush_in     (~cfg_q.en),
		.push_in      (push),
		.push_data_in (hold_f_q),
		.pop_in       (pop),
		.head_out     (head),
		.full_out     (full),
		.empty_out    (empty)
	);

	// Register port; status flags are read-only
	always_comb
	begin
		cfg_d   = cfg_q;
		baud_d  = baud_q;
		rdata_d = '0;
		if (WR_IN)
		begin
			unique case (ADDR_IN)
				ADDR_CTRL:
					cfg_d = rx_cfg_t'(WDATA_IN[6:0]);
				ADDR_BAUD:
					baud_d = WDATA_IN;
				ADDR_STATUS, ADDR_DATA: ;
			endcase
		end
		if (RD_IN)
		begin
			unique case (ADDR_IN)
				ADDR_CTRL:
					rdata_d = {9'h0, cfg_q};
				ADDR_STATUS:
				begin
					rdata_d[ST_RXC] = ~empty;
					rdata_d[ST_FRAME_ERR] = ~empty & head.frame_err;
					rdata_d[ST_DOR] = dor_q;
					rdata_d[ST_UPE] = ~empty & head.upe;
				end
				ADDR_DATA:
					rdata_d = {7'h0, head.data};
				ADDR_BAUD:
					rdata_d = baud_q;
			endcase
		end
	end

	always_ff @(posedge CLK_SYS_IN or negedge RESETN_IN)
	begin
		if (!RESETN_IN)
		begin
			cfg_q   <= rx_cfg_t'(CTRL_RESET[6:0]);
			baud_q  <= BAUD_RESET;
			rdata_q <= '0;
		end
		else
		begin
			cfg_q   <= cfg_d;
			baud_q  <= baud_d;
			rdata_q <= rdata_d;
		end
	end
	assign RDATA_OUT = rdata_q;

	upe_zero_a: assert property (@(posedge CLK_SYS_IN) disable iff (!RESETN_IN)
		(state_q == ST_BITS && state_d == ST_IDLE && cfg_q.en && !cfg_q.par_en) |=> !hold_f_q.upe)
		else $error("parity flag set without checking");
	disable_stop_a: assert property (@(posedge CLK_SYS_IN) disable iff (!RESETN_IN)
		!cfg_q.en |=> state_q == ST_IDLE)
		else $error("receiver ran while disabled");
	flush_empty_a: assert property (@(posedge CLK_SYS_IN) disable iff (!RESETN_IN)
		!cfg_q.en |=> empty)
		else $error("buffer not flushed");
	pin_release_a: assert property (@(posedge CLK_SYS_IN) disable iff (!RESETN_IN)
		RXD_OVERRIDE_OUT == cfg_q.en)
		else $error("pin override wrong");
	rxc_flag_a: assert property (@(posedge CLK_SYS_IN) disable iff (!RESETN_IN)
		(RD_IN && ADDR_IN == ADDR_STATUS) |=> RDATA_OUT[ST_RXC] == !$past(empty))
		else $error("receive complete wrong");
	samp_range_a: assert property (@(posedge CLK_SYS_IN) disable iff (!RESETN_IN)
		state_q == ST_BITS |-> samp_q <= last_samp)
		else $error("sample state out of range");
	start_samp_a: assert property (@(posedge CLK_SYS_IN) disable iff (!RESETN_IN)
		(state_q == ST_IDLE && $past(state_q) == ST_START && $past(cfg_q.en)) |-> $past(samp_q) == $past(vlast))
		else $error("start vote at wrong sample");
	status_ro_a: assert property (@(posedge CLK_SYS_IN) disable iff (!RESETN_IN)
		(WR_IN && ADDR_IN == ADDR_STATUS && !pop && !push && cfg_q.en) |=> $stable(empty))
		else $error("status write altered buffer");
endmodule // uart_async_receiver

// ### uart_tx_model.sv
`timescale 1ns/100ps
module uart_tx_model (
	// Clock
	input  wire logic clk_in,
	// Serial line
	output logic      line_out
);
	initial line_out = 1'b1;

	// Bits go out LSB first, start bit included; the line idles high after
	task automatic send(input logic [11:0] bits, input int n, input int bc);
		for (int i = 0; i < n; i++)
		begin
			line_out <= bits[i];
			repeat (bc) @(posedge clk_in);
		end
		line_out <= 1'b1;
	endtask
endmodule // uart_tx_model

// ### uart_async_receiver_tb.sv
`timescale 1ns/100ps
module uart_async_receiver_tb;
	import rx_pkg::*;
	localparam int BN = 16;
	localparam int BD = 8;
	logic        clk;
	logic        rst_n;
	wire logic   rxd;
	logic        ovr;
	logic [1:0]  addr;
	logic [15:0] wdata;
	logic        wr;
	logic        rd;
	logic [15:0] rdata;
	logic [15:0] v;
	logic        p;
	int          num_errors;
	int          check_count;

	uart_tx_model u_tx (
		.clk_in   (clk),
		.line_out (rxd)
	);

	uart_async_receiver u_dut (
		.CLK_SYS_IN       (clk),
		.RESETN_IN        (rst_n),
		.RXD_IN           (rxd),
		.RXD_OVERRIDE_OUT (ovr),
		.ADDR_IN          (addr),
		.WDATA_IN         (wdata),
		.WR_IN            (wr),
		.RD_IN            (rd),
		.RDATA_OUT        (rdata)
	);

	task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("BAD %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic report_and_stop();
		$display("checks %0d errors %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	task automatic wr_reg(input logic [1:0] a, input logic [15:0] d);
		@(posedge clk);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		wr <= 1'b0;
	endtask

	task automatic rd_reg(input logic [1:0] a);
		@(posedge clk);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		#1 v = rdata;
	endtask

	// Eight data bits always
	task automatic cfg(input logic en, input logic dbl, input logic podd, input logic pen);
		wr_reg(ADDR_CTRL, {9'h0, 3'h3, pen, podd, dbl, en});
	endtask

	task automatic frame(input logic [7:0] d, input logic pb, input logic stop, input logic pen, input int bc);
		@(posedge clk);
		if (pen)
			u_tx.send({1'b0, stop, pb, d, 1'b0}, 11, bc);
		else
			u_tx.send({2'b0, stop, d, 1'b0}, 10, bc);
		repeat (bc) @(posedge clk);
	endtask

	task automatic expect_frame(input logic [7:0] d, input logic ferr, input logic upe);
		rd_reg(ADDR_STATUS);
		check("rxc", {15'h0, v[ST_RXC]}, 16'h1);
		check("frame_err", {15'h0, v[ST_FRAME_ERR]}, {15'h0, ferr});
		check("upe", {15'h0, v[ST_UPE]}, {15'h0, upe});
		rd_reg(ADDR_DATA);
		check("data", {8'h0, v[7:0]}, {8'h0, d});
	endtask

	task automatic expect_empty();
		rd_reg(ADDR_STATUS);
		check("rxc", {15'h0, v[ST_RXC]}, 16'h0);
	endtask

	task automatic t_reset();
		rd_reg(ADDR_CTRL);
		check("ctrl", v, {8'h0, CTRL_RESET});
		rd_reg(ADDR_BAUD);
		check("baud", v, BAUD_RESET);
		check("ovr", {15'h0, ovr}, 16'h0);
		expect_empty();
	endtask

	task automatic t_basic();
		wr_reg(ADDR_BAUD, 16'h0000);
		cfg(1'b1, 1'b0, 1'b0, 1'b0);
		frame(8'ha5, 1'b0, 1'b1, 1'b0, BN);
		expect_frame(8'ha5, 1'b0, 1'b0);
		check("ovr", {15'h0, ovr}, 16'h1);
		expect_empty();
		// Broken stop bit, then a status write of zero must not clear the flag
		frame(8'h3c, 1'b0, 1'b0, 1'b0, BN);
		wr_reg(ADDR_STATUS, 16'h0000);
		expect_frame(8'h3c, 1'b1, 1'b0);
	endtask

	task automatic t_parity();
		for (int m = 0; m < 4; m++)
		begin
			cfg(1'b1, 1'b0, m[0], 1'b1);
			p = (^8'h6b) ^ m[0] ^ m[1];
			frame(8'h6b, p, 1'b1, 1'b1, BN);
			expect_frame(8'h6b, 1'b0, m[1]);
		end
		// Checker off: odd select set, no error may show
		cfg(1'b1, 1'b0, 1'b1, 1'b0);
		frame(8'h6b, 1'b1, 1'b1, 1'b0, BN);
		expect_frame(8'h6b, 1'b0, 1'b0);
	endtask

	// Nine and five data bits; bits above the size read as zero
	task automatic t_size();
		wr_reg(ADDR_CTRL, 16'h0041);
		@(posedge clk);
		u_tx.send({1'b0, 1'b1, 9'h1a5, 1'b0}, 11, BN);
		repeat (BN) @(posedge clk);
		rd_reg(ADDR_DATA);
		check("data9", v, 16'h01a5);
		wr_reg(ADDR_CTRL, 16'h0001);
		@(posedge clk);
		u_tx.send({5'h00, 1'b1, 5'h15, 1'b0}, 7, BN);
		repeat (BN) @(posedge clk);
		rd_reg(ADDR_DATA);
		check("data5", v, 16'h0015);
	endtask

	task automatic t_double_noise();
		cfg(1'b1, 1'b1, 1'b0, 1'b0);
		frame(8'h5a, 1'b0, 1'b1, 1'b0, BD);
		expect_frame(8'h5a, 1'b0, 1'b0);
		cfg(1'b1, 1'b0, 1'b0, 1'b0);
		@(posedge clk);
		u_tx.send(12'h000, 1, 5);
		repeat (40) @(posedge clk);
		expect_empty();
		frame(8'h81, 1'b0, 1'b1, 1'b0, BN);
		expect_frame(8'h81, 1'b0, 1'b0);
	endtask

	task automatic t_overrun();
		for (int i = 0; i < 4; i++)
			frame(8'h10 + 8'(i), 1'b0, 1'b1, 1'b0, BN);
		expect_frame(8'h10, 1'b0, 1'b0);
		expect_frame(8'h11, 1'b0, 1'b0);
		rd_reg(ADDR_STATUS);
		check("dor", {15'h0, v[ST_DOR]}, 16'h1);
		// Drain by reading data until receive complete drops
		for (int i = 0; i < 4 && v[ST_RXC] === 1'b1; i++)
		begin
			rd_reg(ADDR_DATA);
			rd_reg(ADDR_STATUS);
		end
		expect_empty();
	endtask

	task automatic t_disable();
		frame(8'h77, 1'b0, 1'b1, 1'b0, BN);
		cfg(1'b0, 1'b0, 1'b0, 1'b0);
		expect_empty();
		check("ovr", {15'h0, ovr}, 16'h0);
		cfg(1'b1, 1'b0, 1'b0, 1'b0);
		fork
			frame(8'h00, 1'b0, 1'b1, 1'b0, BN);
			begin
				repeat (60) @(posedge clk);
				cfg(1'b0, 1'b0, 1'b0, 1'b0);
			end
		join
		cfg(1'b1, 1'b0, 1'b0, 1'b0);
		expect_empty();
	endtask

	initial
	begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	initial
	begin
		repeat (40000) @(posedge clk);
		num_errors++;
		report_and_stop();
	end

	initial
	begin
		rst_n = 1'b0;
		wr = 1'b0;
		rd = 1'b0;
		addr = 2'h0;
		wdata = 16'h0000;
		num_errors = 0;
		check_count = 0;
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		t_reset();
		t_basic();
		t_parity();
		t_size();
		t_double_noise();
		t_overrun();
		t_disable();
		report_and_stop();
	end
endmodule // uart_async_receiver_tb
